// File: hdl/cfs_pkg.sv
// Purpose: shared constants and types for the transceiver fail-safe controller
// Assumes: 50 MHz clock, one clock domain
// Notes: times are kept in ns and converted to cycle counts here
package cfs_pkg;
   localparam int unsigned CLK_PERIOD_NS = 20;
   // least times round up; figures are plain defaults
   localparam int unsigned DOM_TIMEOUT_NS = 1000000;
   localparam int unsigned UV_DETECT_NS = 10000;
   localparam int unsigned SWOFF_DETECT_NS = 10000;
   localparam int unsigned IO_FILTER_NS = 1000;
   localparam int unsigned WAKE_FILTER_NS = 1000;
   localparam int unsigned WAKE_TIMEOUT_NS = 1000000;
   localparam int unsigned RXD_STARTUP_NS = 20000;
   localparam int unsigned DOM_TIMEOUT_CYC = (DOM_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned UV_DETECT_CYC = (UV_DETECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned SWOFF_DETECT_CYC = (SWOFF_DETECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned IO_FILTER_CYC = (IO_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned WAKE_FILTER_CYC = (WAKE_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned WAKE_TIMEOUT_CYC = WAKE_TIMEOUT_NS / CLK_PERIOD_NS;
   localparam int unsigned RXD_STARTUP_CYC = (RXD_STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned CNT_W = 20;

   typedef enum logic [1:0] {CFS_OFF, CFS_STANDBY, CFS_NORMAL} cfs_mode_t;
   typedef enum logic [2:0] {WK_IDLE, WK_DOM1, WK_REC, WK_DOM2, WK_DONE} cfs_wake_t;

   // supply and thermal indications, already synchronised
   typedef struct packed {
      logic stb_uv;
      logic swoff_uv;
      logic temp_hot;
      logic temp_rel;
   } cfs_sense_t;
endpackage : cfs_pkg

// File: hdl/cfs_qual.sv
// Purpose: qualifies a level that must persist a number of cycles
// Assumes: input synchronous to clk
// Notes: output follows input only after LIMIT equal samples
`timescale 1ns/100ps
`default_nettype none
module cfs_qual
   import cfs_pkg::*;
#(
   parameter int unsigned LIMIT = 4,
   parameter logic INIT = 1'b0
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic din,
   output logic qout
);
   logic [CNT_W-1:0] cnt_ff;
   logic [CNT_W-1:0] nxt_cnt;
   logic qout_ff;
   logic differs;
   logic done;

   // count while the raw level differs from the filtered one
   assign differs = din != qout_ff;
   assign done = differs && (cnt_ff >= CNT_W'(LIMIT - 1));
   assign nxt_cnt = (differs && !done) ? cnt_ff + CNT_W'(1) : '0;
   assign qout = qout_ff;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         cnt_ff <= '0;
         qout_ff <= INIT;
      end else begin
         cnt_ff <= nxt_cnt;
         if (done) begin
            qout_ff <= din;
         end
      end
   end
endmodule // cfs_qual
`default_nettype wire

// File: hdl/cfs_ctrl.sv
// Purpose: fail-safe and mode supervision of a CAN FD transceiver
// Assumes: all inputs synchronous to clk; supply power-up drives resetn
// Notes: the analog front end consumes tx_drive_en and bus_hiz
`timescale 1ns/100ps
`default_nettype none
// Function
// - start dominant timer when transmit input low
// - disable transmitter after dominant time-out
// - clear dominant timer when transmit returns high
// - floating transmit and standby inputs read high
// - persistent standby undervoltage forces Standby mode
// - ignore standby input during undervoltage
// - persistent switch-off undervoltage forces Off, hi-z
// - overtemperature disables bus drivers
// - recover when cool, transmit high, Normal selected
// - filter short pulses on standby input
// - hold receive high during start-up interval
// - first qualified dominant after start-up drives low; the code does not show one still running when start-up ends
// - standby high selects Standby, low Normal
// - wake needs dom-rec-dom within time-out
// - no transmit until transmit seen high
module cfs_ctrl
   import cfs_pkg::*;
#(
   parameter int unsigned DOM_TO = DOM_TIMEOUT_CYC,
   parameter int unsigned WAKE_TO = WAKE_TIMEOUT_CYC,
   parameter int unsigned RX_START = RXD_STARTUP_CYC,
   parameter int unsigned UV_DET = UV_DETECT_CYC,
   parameter int unsigned SWOFF_DET = SWOFF_DETECT_CYC
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic txd_in,
   input wire logic txd_driven,
   input wire logic stb_in,
   input wire logic stb_driven,
   input wire cfs_sense_t sense,
   input wire logic bus_dom,
   input wire logic rx_normal,
   output logic rxd_out,
   output logic tx_drive_en,
   output logic bus_hiz,
   output cfs_mode_t mode,
   output logic wake_flag
);
   cfs_mode_t mode_ff, nxt_mode;
   cfs_wake_t wk_ff, nxt_wk;
   logic txd_lvl, stb_lvl, stb_filt, uv_q, swoff_q, bus_q;
   logic [CNT_W-1:0] dom_cnt_ff, wk_cnt_ff, st_cnt_ff;
   logic dom_to_ff, hot_ff, txd_seen_ff, wake_ff, rx_act_ff, rxd_ff;
   logic dom_expired, wk_expired, st_done, uv_hold;

   // saturating increment shared by all interval counters
   function automatic logic [CNT_W-1:0] bump(input logic [CNT_W-1:0] v, input int unsigned lim);
      bump = (v >= CNT_W'(lim)) ? v : v + CNT_W'(1);
   endfunction

   // pull-ups: an undriven pin reads high
   assign txd_lvl = txd_driven ? txd_in : 1'b1;
   assign stb_lvl = stb_driven ? stb_in : 1'b1;

   // standby input deglitch and supply/bus qualification
   cfs_qual #(.LIMIT(IO_FILTER_CYC), .INIT(1'b1)) u_stb (.clk(clk), .resetn(resetn),
      .din(stb_lvl), .qout(stb_filt));
   cfs_qual #(.LIMIT(UV_DET), .INIT(1'b0)) u_uv (.clk(clk), .resetn(resetn),
      .din(sense.stb_uv), .qout(uv_q));
   cfs_qual #(.LIMIT(SWOFF_DET), .INIT(1'b1)) u_swoff (.clk(clk), .resetn(resetn),
      .din(sense.swoff_uv), .qout(swoff_q));
   cfs_qual #(.LIMIT(WAKE_FILTER_CYC), .INIT(1'b0)) u_bus (.clk(clk), .resetn(resetn),
      .din(bus_dom), .qout(bus_q));

   // mode selection; undervoltage masks the standby input
   assign uv_hold = uv_q || sense.stb_uv;
   always_comb begin
      if (swoff_q) begin
         nxt_mode = CFS_OFF;
      end else if (uv_q) begin
         nxt_mode = CFS_STANDBY;
      end else if (uv_hold) begin
         nxt_mode = mode_ff;
      end else begin
         nxt_mode = stb_filt ? CFS_STANDBY : CFS_NORMAL;
      end
   end

   // counters saturate at their limit, so a level stuck for ages cannot wrap them
   assign dom_expired = dom_cnt_ff >= CNT_W'(DOM_TO);
   assign wk_expired = wk_cnt_ff >= CNT_W'(WAKE_TO);
   assign st_done = st_cnt_ff >= CNT_W'(RX_START);

   // wake pattern detector; reset on time-out or leaving Standby
   always_comb begin
      nxt_wk = wk_ff;
      unique case (wk_ff)
         WK_IDLE: if (bus_q) nxt_wk = WK_DOM1;
         WK_DOM1: if (!bus_q) nxt_wk = WK_REC;
         WK_REC: if (bus_q) nxt_wk = WK_DOM2;
         WK_DOM2: nxt_wk = WK_DONE;
         WK_DONE: nxt_wk = WK_DONE;
         default: nxt_wk = WK_IDLE;
      endcase
      if (mode_ff != CFS_STANDBY) begin
         nxt_wk = WK_IDLE;
      end else if (wk_expired && wk_ff != WK_DONE) begin
         nxt_wk = WK_IDLE;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         mode_ff <= CFS_OFF;
         wk_ff <= WK_IDLE;
         dom_cnt_ff <= '0;
         wk_cnt_ff <= '0;
         st_cnt_ff <= '0;
         dom_to_ff <= 1'b0;
         hot_ff <= 1'b0;
         txd_seen_ff <= 1'b0;
      end else begin
         mode_ff <= nxt_mode;
         wk_ff <= nxt_wk;
         // dominant timer runs while low, clears when high
         dom_cnt_ff <= txd_lvl ? '0 : bump(dom_cnt_ff, DOM_TO);
         if (txd_lvl) begin
            dom_to_ff <= 1'b0;
         end else if (dom_expired) begin
            dom_to_ff <= 1'b1;
         end
         // overtemperature latch; release waits for txd high and Normal
         if (sense.temp_hot) begin
            hot_ff <= 1'b1;
         end else if (sense.temp_rel && txd_lvl && mode_ff == CFS_NORMAL) begin
            hot_ff <= 1'b0;
         end
         txd_seen_ff <= (mode_ff == CFS_NORMAL) && (txd_seen_ff || txd_lvl);
         wk_cnt_ff <= (wk_ff == WK_IDLE || wk_ff == WK_DONE) ? '0 : bump(wk_cnt_ff, WAKE_TO);
         st_cnt_ff <= (wk_ff == WK_DONE) ? bump(st_cnt_ff, RX_START) : '0;
      end
   end

   // receive output gating after wake-up
   always_ff @(posedge clk) begin
      if (!resetn) begin
         wake_ff <= 1'b0;
         rx_act_ff <= 1'b0;
         rxd_ff <= 1'b1;
      end else begin
         wake_ff <= (mode_ff == CFS_STANDBY) && (wk_ff == WK_DONE);
         // a dominant still running when start-up ends only arms the output;
         // limitation: that pulse itself is never shown, the next one is
         if (wk_ff != WK_DONE) begin
            rx_act_ff <= 1'b0;
         end else if (st_done && !bus_q) begin
            rx_act_ff <= 1'b1; // set once the bus reads recessive after start-up
         end
         if (mode_ff == CFS_NORMAL) begin
            rxd_ff <= !rx_normal;
         end else if (rx_act_ff) begin
            rxd_ff <= !bus_q;
         end else begin
            rxd_ff <= 1'b1;
         end
      end
   end

   // gated combinationally so a rising transmit input stops the driver at once
   assign tx_drive_en = (mode_ff == CFS_NORMAL) && !dom_to_ff && !hot_ff && txd_seen_ff
                        && !txd_lvl;
   assign bus_hiz = mode_ff == CFS_OFF;
   assign mode = mode_ff;
   assign wake_flag = wake_ff;
   assign rxd_out = rxd_ff;

   // checks on the supervision logic, all on the one clock
   ctrl_dom_to_a: assert property (@(posedge clk) disable iff (!resetn)
      dom_to_ff |-> !tx_drive_en) else $error("transmit active after time-out");
   ctrl_dom_clr_a: assert property (@(posedge clk) disable iff (!resetn)
      txd_lvl |=> dom_cnt_ff == '0) else $error("dominant timer not cleared");
   ctrl_dom_run_a: assert property (@(posedge clk) disable iff (!resetn)
      (!txd_lvl && !dom_expired) |=> dom_cnt_ff == $past(dom_cnt_ff) + CNT_W'(1))
      else $error("dominant timer not counting");
   ctrl_pullup_a: assert property (@(posedge clk) disable iff (!resetn)
      !txd_driven |-> txd_lvl) else $error("floating transmit not high");
   ctrl_uv_stby_a: assert property (@(posedge clk) disable iff (!resetn)
      (uv_q && !swoff_q) |=> mode_ff == CFS_STANDBY) else $error("no standby on undervoltage");
   ctrl_uv_hold_a: assert property (@(posedge clk) disable iff (!resetn)
      (uv_hold && !uv_q && !swoff_q) |=> mode_ff == $past(mode_ff))
      else $error("standby input honoured during undervoltage");
   ctrl_off_hiz_a: assert property (@(posedge clk) disable iff (!resetn)
      swoff_q |=> bus_hiz) else $error("no Off on switch-off undervoltage");
   ctrl_hot_a: assert property (@(posedge clk) disable iff (!resetn)
      sense.temp_hot |=> !tx_drive_en) else $error("drivers on while hot");
   ctrl_rel_a: assert property (@(posedge clk) disable iff (!resetn)
      $fell(hot_ff) |-> $past(txd_lvl) && $past(mode_ff) == CFS_NORMAL)
      else $error("early thermal recovery");
   ctrl_rx_start_a: assert property (@(posedge clk) disable iff (!resetn)
      (mode_ff == CFS_STANDBY && !st_done) |=> rxd_out) else $error("receive low in start-up");
   ctrl_txseen_a: assert property (@(posedge clk) disable iff (!resetn)
      $rose(mode_ff == CFS_NORMAL) |-> !tx_drive_en) else $error("transmit before high seen");
   ctrl_stb_norm_a: assert property (@(posedge clk) disable iff (!resetn)
      (!swoff_q && !uv_hold && !stb_filt) |=> mode_ff == CFS_NORMAL)
      else $error("low standby input did not select Normal");
   ctrl_stb_stby_a: assert property (@(posedge clk) disable iff (!resetn)
      (!swoff_q && !uv_hold && stb_filt) |=> mode_ff == CFS_STANDBY)
      else $error("high standby input did not select Standby");
   ctrl_stb_filt_a: assert property (@(posedge clk) disable iff (!resetn)
      $changed(stb_filt) |-> stb_filt == $past(stb_lvl))
      else $error("filtered standby level wrong");
   ctrl_wk_to_a: assert property (@(posedge clk) disable iff (!resetn)
      (wk_expired && wk_ff != WK_DONE) |=> wk_ff == WK_IDLE)
      else $error("wake detector not reset on time-out");
   ctrl_wk_leave_a: assert property (@(posedge clk) disable iff (!resetn)
      (mode_ff != CFS_STANDBY) |=> wk_ff == WK_IDLE)
      else $error("wake detector kept outside Standby");
   ctrl_hot_hold_a: assert property (@(posedge clk) disable iff (!resetn)
      (hot_ff && !sense.temp_rel) |=> hot_ff)
      else $error("thermal latch released while hot");
   ctrl_rx_gate_a: assert property (@(posedge clk) disable iff (!resetn)
      (mode_ff == CFS_STANDBY && !rx_act_ff) |=> rxd_out)
      else $error("receive output not held high");

   // covers for the main scenarios
   ctrl_rx_c: cover property (@(posedge clk) disable iff (!resetn) $rose(rx_act_ff));
   ctrl_wake_c: cover property (@(posedge clk) disable iff (!resetn) $rose(wake_flag));
   ctrl_dom_c: cover property (@(posedge clk) disable iff (!resetn) $rose(dom_to_ff));
   ctrl_hot_c: cover property (@(posedge clk) disable iff (!resetn) $fell(hot_ff));
   ctrl_norm_c: cover property (@(posedge clk) disable iff (!resetn) mode_ff == CFS_NORMAL);
endmodule // cfs_ctrl
`default_nettype wire

// File: tb/cfs_mcu_model.sv
// Purpose: controller side model driving the transmit and standby pins
// Assumes: bench sets commanded levels just after the rising edge
// Notes: a released pin floats, so the model shows the inverse of its last level
`timescale 1ns/100ps
`default_nettype none
module cfs_mcu_model (
   input wire logic clk,
   input wire logic drv_txd,
   input wire logic cmd_txd,
   input wire logic drv_stb,
   input wire logic cmd_stb,
   output logic txd_in,
   output logic txd_driven,
   output logic stb_in,
   output logic stb_driven
);
   logic txd_last_ff, stb_last_ff;
   // remember the last driven level so a float never looks like it
   always_ff @(posedge clk) begin
      if (drv_txd) txd_last_ff <= cmd_txd;
      if (drv_stb) stb_last_ff <= cmd_stb;
   end
   // released pins show the inverse level; only the pull-up can make a pin last driven high read high
   assign txd_in = drv_txd ? cmd_txd : ~txd_last_ff;
   assign stb_in = drv_stb ? cmd_stb : ~stb_last_ff;
   assign txd_driven = drv_txd;
   assign stb_driven = drv_stb;
endmodule // cfs_mcu_model
`default_nettype wire

// File: tb/cfs_ctrl_bench.sv
// Purpose: self-checking bench for the fail-safe controller
// Assumes: short interval parameters so the run stays brief
// Notes: inputs change 1 ns after the rising edge
`timescale 1ns/100ps
`default_nettype none
module cfs_ctrl_bench;
   import cfs_pkg::*;
   localparam int DTO = 20, WTO = 400, RXS = 100, UVD = 20, SWD = 20;
   logic clk = 1'b0, resetn = 1'b0, bus_dom = 1'b0, rx_normal = 1'b0;
   logic m_txd = 1'b0, m_tdrv = 1'b1, m_stb = 1'b1, m_sdrv = 1'b1;
   cfs_sense_t sense = 4'h5;
   logic txd_in, txd_driven, stb_in, stb_driven, rxd_out, tx_drive_en, bus_hiz, wake_flag;
   cfs_mode_t mode;
   int num_errors = 0, n_checks = 0;
   cfs_mcu_model cfs_mcu_model_inst (.clk(clk), .drv_txd(m_tdrv), .cmd_txd(m_txd),
      .drv_stb(m_sdrv), .cmd_stb(m_stb), .txd_in(txd_in), .txd_driven(txd_driven),
      .stb_in(stb_in), .stb_driven(stb_driven));
   cfs_ctrl #(.DOM_TO(DTO), .WAKE_TO(WTO), .RX_START(RXS), .UV_DET(UVD), .SWOFF_DET(SWD))
   cfs_ctrl_inst (.clk(clk), .resetn(resetn), .txd_in(txd_in), .txd_driven(txd_driven),
      .stb_in(stb_in), .stb_driven(stb_driven), .sense(sense), .bus_dom(bus_dom),
      .rx_normal(rx_normal), .rxd_out(rxd_out), .tx_drive_en(tx_drive_en),
      .bus_hiz(bus_hiz), .mode(mode), .wake_flag(wake_flag));
   // free-running 50 MHz clock
   initial begin
      forever #10 clk = ~clk;
   end
   task automatic chk(string what, logic [1:0] seen, logic [1:0] exp);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic cyc(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // txd goes low just before Normal, so only the first-high gate keeps it off
   task automatic t_power();
      sense.swoff_uv = 1'b0;
      cyc(SWD + 60);
      chk("mode up", 2'(mode), 2'(CFS_STANDBY));
      chk("hiz up", 2'(bus_hiz), 2'h0);
      m_stb = 1'b0;
      m_txd = 1'b1;
      cyc(30);
      chk("mode filt", 2'(mode), 2'(CFS_STANDBY));
      cyc(12);
      m_txd = 1'b0;
      cyc(13);
      chk("mode norm", 2'(mode), 2'(CFS_NORMAL));
      chk("tx unseen", 2'(tx_drive_en), 2'h0);
      m_txd = 1'b1;
      cyc(3);
      m_txd = 1'b0;
      cyc(DTO);
      chk("tx early", 2'(tx_drive_en), 2'h1);
      cyc(1);
      chk("tx timeout", 2'(tx_drive_en), 2'h0);
      m_txd = 1'b1;
      cyc(2);
      m_txd = 1'b0;
      cyc(2);
      chk("tx cleared", 2'(tx_drive_en), 2'h1);
      $display("test power done");
   endtask
   // short standby glitch, normal receive path, thermal latch and recovery
   task automatic t_glitch_thermal();
      m_txd = 1'b1;
      m_stb = 1'b1;
      cyc(10);
      chk("mode glitch", 2'(mode), 2'(CFS_NORMAL));
      m_stb = 1'b0;
      rx_normal = 1'b1;
      cyc(60);
      chk("rxd normal", 2'(rxd_out), 2'h0);
      rx_normal = 1'b0;
      m_txd = 1'b0;
      sense.temp_hot = 1'b1;
      sense.temp_rel = 1'b0;
      cyc(3);
      chk("tx hot", 2'(tx_drive_en), 2'h0);
      sense.temp_hot = 1'b0;
      sense.temp_rel = 1'b1;
      cyc(3);
      chk("tx cool low", 2'(tx_drive_en), 2'h0);
      m_txd = 1'b1;
      cyc(2);
      m_txd = 1'b0;
      cyc(2);
      chk("tx recover", 2'(tx_drive_en), 2'h1);
      m_txd = 1'b1;
      $display("test thermal done");
   endtask
   // undervoltage overrides standby input, then floating pins read high
   task automatic t_uv_float();
      sense.stb_uv = 1'b1;
      cyc(UVD + 5);
      chk("mode uv", 2'(mode), 2'(CFS_STANDBY));
      cyc(60);
      chk("mode uv hold", 2'(mode), 2'(CFS_STANDBY));
      sense.stb_uv = 1'b0;
      cyc(60);
      chk("mode uv rec", 2'(mode), 2'(CFS_NORMAL));
      m_tdrv = 1'b0;
      cyc(10);
      chk("tx float", 2'(tx_drive_en), 2'h0);
      m_tdrv = 1'b1;
      m_txd = 1'b0;
      cyc(2);
      chk("tx no timer", 2'(tx_drive_en), 2'h1);
      m_txd = 1'b1;
      m_stb = 1'b1;
      cyc(60);
      m_sdrv = 1'b0;
      cyc(60);
      chk("mode float", 2'(mode), 2'(CFS_STANDBY));
      m_sdrv = 1'b1;
      $display("test uv done");
   endtask
   // lone dominant times out, full pattern wakes, rxd gated during start-up
   task automatic t_wake_off();
      bus_dom = 1'b1;
      cyc(70);
      bus_dom = 1'b0;
      cyc(WTO + 20);
      chk("wake lone", 2'(wake_flag), 2'h0);
      bus_dom = 1'b1;
      cyc(70);
      chk("wake restart", 2'(wake_flag), 2'h0);
      bus_dom = 1'b0;
      cyc(70);
      bus_dom = 1'b1;
      cyc(70);
      chk("wake seen", 2'(wake_flag), 2'h1);
      chk("rxd startup", 2'(rxd_out), 2'h1);
      bus_dom = 1'b0;
      cyc(70);
      bus_dom = 1'b1;
      cyc(70);
      chk("rxd follow", 2'(rxd_out), 2'h0);
      bus_dom = 1'b0;
      cyc(70);
      chk("rxd release", 2'(rxd_out), 2'h1);
      sense.swoff_uv = 1'b1;
      cyc(SWD + 5);
      chk("mode off", 2'(mode), 2'(CFS_OFF));
      chk("hiz off", 2'(bus_hiz), 2'h1);
      $display("test wake done");
   endtask
   // a hang counts as a mismatch; the scenarios need about 1,460 cycles
   initial begin
      cyc(4000);
      num_errors++;
      $display("watchdog expired");
      test_done();
   end
   // main sequence
   initial begin
      cyc(4);
      chk("mode rst", 2'(mode), 2'(CFS_OFF));
      chk("hiz rst", 2'(bus_hiz), 2'h1);
      chk("out rst", {rxd_out, tx_drive_en}, 2'h2);
      chk("wake rst", 2'(wake_flag), 2'h0);
      resetn = 1'b1;
      t_power();
      t_glitch_thermal();
      t_uv_float();
      t_wake_off();
      test_done();
   end
endmodule // cfs_ctrl_bench
`default_nettype wire
